// >>> rtl/dcd_map.svh
// constants for the sdram command decoder and its controller
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH
`define DCD_BA_W 3
`define DCD_ADDR_W 14
`define DCD_A10 10
`define DCD_A12 12
`define DCD_BURST8 4'h8
`define DCD_BURST4 4'h4
`define DCD_WL_DEF 4'h5
`define DCD_SRX_WAIT 10'h200
`define DCD_BANKS 8
`endif

// >>> rtl/dcd_pkg.sv
// types shared by the command decoder and its controller
`include "dcd_map.svh"
package dcd_pkg;
	typedef enum logic [14:0] {
		DCD_C_NONE = 15'h0001,
		DCD_C_MRS = 15'h0002,
		DCD_C_REF = 15'h0004,
		DCD_C_SRE = 15'h0008,
		DCD_C_SRX = 15'h0010,
		DCD_C_PRE = 15'h0020,
		DCD_C_PREA = 15'h0040,
		DCD_C_ACT = 15'h0080,
		DCD_C_WR = 15'h0100,
		DCD_C_RD = 15'h0200,
		DCD_C_PDE = 15'h0400,
		DCD_C_PDX = 15'h0800,
		DCD_C_ZQCL = 15'h1000,
		DCD_C_ZQCS = 15'h2000,
		DCD_C_ILL = 15'h4000
	} dcd_cmd_e;
	typedef enum logic [3:0] {
		DCD_S_IDLE = 4'h1,
		DCD_S_PD = 4'h2,
		DCD_S_SR = 4'h4,
		DCD_S_RST = 4'h8
	} dcd_pwr_e;
endpackage

// >>> rtl/dcd_if.sv
// command and address pins between controller and sdram
`timescale 1ns/10ps
`default_nettype none
`include "dcd_map.svh"
interface dcd_if;
	logic reset_n;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic odt;
	logic [`DCD_BA_W-1:0] ba;
	logic [`DCD_ADDR_W-1:0] addr;
	modport ctrl (output reset_n, output cke, output cs_n, output ras_n, output cas_n,
		output we_n, output odt, output ba, output addr);
	modport dev (input reset_n, input cke, input cs_n, input ras_n, input cas_n,
		input we_n, input odt, input ba, input addr);
endinterface
`default_nettype wire

// >>> rtl/dcd_device.sv
// sdram command decoder, device end
// Functional notes
// - decode only strobes and cke at edge
// - reset pin low resets asynchronously
// - bank lines pick bank or mode register
// - write decoded, mode burst when a12 unused
// - on-the-fly a12 picks chop or eight
// - a10 with read/write requests auto precharge
// - read decoded with bank and column
// - bursts run to completion, never interrupted
// - mode register picks fixed or on-the-fly
// - nop registers nothing, aborts nothing
// - controller idles with nop commands
// - deselect ignores inputs, acts as nop
// - power-down performs no refresh
// - odt ignored; unavailable in self refresh
// - cke rise with nop exits self refresh
// - 512 clocks after exit before write
// - entry/exit overlap gives uncertain termination
// - exit/entry overlap gives uncertain termination
// - power-down edges only with nop/deselect
// - self refresh entry only when idle
// - entry window starts wl-1 before cke low; decoder opens it at the cke edge
`timescale 1ns/10ps
`default_nettype none
`include "dcd_map.svh"
module dcd_device
	import dcd_pkg::*;
(
	input wire logic clk_sys,
	dcd_if.dev pins,
	input wire logic [3:0] wr_lat,
	output dcd_cmd_e cmd,
	output logic cmd_valid,
	output logic [`DCD_BA_W-1:0] cmd_bank,
	output logic [`DCD_ADDR_W-1:0] cmd_addr,
	output logic [3:0] cmd_burst,
	output logic cmd_autopre,
	output logic burst_busy,
	output logic [`DCD_BANKS-1:0] bank_open,
	output logic [1:0] mr_otf,
	output dcd_pwr_e pwr_state,
	output logic refresh_active,
	output logic odt_uncertain,
	output logic odt_enabled
);
	logic cke_prev_ff;
	logic otf_ff;
	logic fixed4_ff;
	logic [3:0] burst_cnt_ff;
	logic [3:0] nxt_burst_cnt;
	logic [3:0] win_cnt_ff;
	dcd_cmd_e dec;
	dcd_pwr_e pwr_ff;
	logic [3:0] nxt_len;
	logic nop_like;
	logic [`DCD_BA_W-1:0] cmd_bank_ff;
	logic [`DCD_ADDR_W-1:0] cmd_addr_ff;
	logic [3:0] cmd_burst_ff;
	logic cmd_autopre_ff;
	dcd_cmd_e cmd_ff;
	logic [`DCD_BANKS-1:0] bank_open_ff;

	// command and cke history only, odt never looked at
	always_comb begin
		nop_like = pins.cs_n || (pins.ras_n && pins.cas_n && pins.we_n);
		dec = DCD_C_ILL;
		if (cke_prev_ff && pins.cke) begin
			if (pins.cs_n) begin
				dec = DCD_C_NONE;
			end else begin
				case ({pins.ras_n, pins.cas_n, pins.we_n})
					3'h0: dec = DCD_C_MRS;
					3'h1: dec = DCD_C_REF;
					3'h2: dec = pins.addr[`DCD_A10] ? DCD_C_PREA : DCD_C_PRE;
					3'h3: dec = DCD_C_ACT;
					3'h4: dec = DCD_C_WR;
					3'h5: dec = DCD_C_RD;
					3'h6: dec = pins.addr[`DCD_A10] ? DCD_C_ZQCL : DCD_C_ZQCS;
					default: dec = DCD_C_NONE;
				endcase
			end
		end else if (cke_prev_ff && !pins.cke) begin
			if (!pins.cs_n && !pins.ras_n && !pins.cas_n && pins.we_n) begin
				dec = DCD_C_SRE;
			end else if (nop_like) begin
				dec = DCD_C_PDE;
			end
		end else if (!cke_prev_ff && pins.cke) begin
			if (nop_like) begin
				dec = (pwr_ff == DCD_S_SR) ? DCD_C_SRX : DCD_C_PDX;
			end
		end else begin
			dec = DCD_C_NONE;
		end
		// reads and writes are refused while more than one cycle of the running burst remains
		if ((dec == DCD_C_RD || dec == DCD_C_WR) && burst_cnt_ff > 4'h1) begin
			dec = DCD_C_ILL;
		end
		// self refresh and power-down exits only from matching power state
		if ((dec == DCD_C_SRX && pwr_ff != DCD_S_SR) || (dec == DCD_C_PDX && pwr_ff != DCD_S_PD)) begin
			dec = DCD_C_ILL;
		end
	end

	// a12 only counts with on-the-fly mode
	always_comb begin
		if (otf_ff) begin
			nxt_len = pins.addr[`DCD_A12] ? `DCD_BURST8 : `DCD_BURST4;
		end else begin
			nxt_len = fixed4_ff ? `DCD_BURST4 : `DCD_BURST8;
		end
	end

	always_ff @(posedge clk_sys or negedge pins.reset_n) begin
		if (!pins.reset_n) begin
			cke_prev_ff <= 1'b0;
		end else begin
			cke_prev_ff <= pins.cke;
		end
	end

	// mode register 0 burst field: bits 1:0, 00 fixed 8, 01 otf, 10 fixed 4
	always_ff @(posedge clk_sys or negedge pins.reset_n) begin
		if (!pins.reset_n) begin
			otf_ff <= 1'b0;
			fixed4_ff <= 1'b0;
		end else if (dec == DCD_C_MRS && pins.ba == 3'h0) begin
			otf_ff <= (pins.addr[1:0] == 2'h1);
			fixed4_ff <= (pins.addr[1:0] == 2'h2);
		end
	end

	always_comb begin
		nxt_burst_cnt = (burst_cnt_ff != 4'h0) ? burst_cnt_ff - 4'h1 : 4'h0;
		if (dec == DCD_C_RD || dec == DCD_C_WR) begin
			nxt_burst_cnt = nxt_len;
		end
	end

	// nop and deselect leave the count running
	always_ff @(posedge clk_sys or negedge pins.reset_n) begin
		if (!pins.reset_n) begin
			burst_cnt_ff <= 4'h0;
		end else begin
			burst_cnt_ff <= nxt_burst_cnt;
		end
	end

	always_ff @(posedge clk_sys or negedge pins.reset_n) begin
		if (!pins.reset_n) begin
			cmd_ff <= DCD_C_NONE;
			cmd_bank_ff <= '0;
			cmd_addr_ff <= '0;
			cmd_burst_ff <= 4'h0;
			cmd_autopre_ff <= 1'b0;
		end else begin
			cmd_ff <= dec;
			if (dec != DCD_C_NONE && dec != DCD_C_ILL) begin
				cmd_bank_ff <= pins.ba;
				cmd_addr_ff <= pins.addr;
				cmd_burst_ff <= (dec == DCD_C_RD || dec == DCD_C_WR) ? nxt_len : 4'h0;
				cmd_autopre_ff <= (dec == DCD_C_RD || dec == DCD_C_WR) && pins.addr[`DCD_A10];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge pins.reset_n) begin
		if (!pins.reset_n) begin
			bank_open_ff <= '0;
		end else begin
			case (dec)
				DCD_C_ACT: bank_open_ff[pins.ba] <= 1'b1;
				DCD_C_PRE: bank_open_ff[pins.ba] <= 1'b0;
				DCD_C_PREA: bank_open_ff <= '0;
				DCD_C_RD, DCD_C_WR: begin
					if (pins.addr[`DCD_A10]) begin
						bank_open_ff[pins.ba] <= 1'b0;
					end
				end
				default: bank_open_ff <= bank_open_ff;
			endcase
		end
	end

	// no refresh of its own in power-down
	always_ff @(posedge clk_sys or negedge pins.reset_n) begin
		if (!pins.reset_n) begin
			pwr_ff <= DCD_S_IDLE;
		end else begin
			case (dec)
				DCD_C_SRE: pwr_ff <= DCD_S_SR;
				DCD_C_PDE: pwr_ff <= DCD_S_PD;
				DCD_C_SRX, DCD_C_PDX: pwr_ff <= DCD_S_IDLE;
				default: pwr_ff <= pwr_ff;
			endcase
		end
	end

	// uncertain window: opened at the cke edge, held through power-down and wl-1 after
	always_ff @(posedge clk_sys or negedge pins.reset_n) begin
		if (!pins.reset_n) begin
			win_cnt_ff <= 4'h0;
		end else if (dec == DCD_C_PDE || dec == DCD_C_PDX) begin
			win_cnt_ff <= wr_lat - 4'h1;
		end else if (win_cnt_ff != 4'h0) begin
			win_cnt_ff <= win_cnt_ff - 4'h1;
		end
	end

	assign cmd = cmd_ff;
	assign cmd_valid = (cmd_ff != DCD_C_NONE) && (cmd_ff != DCD_C_ILL);
	assign cmd_bank = cmd_bank_ff;
	assign cmd_addr = cmd_addr_ff;
	assign cmd_burst = cmd_burst_ff;
	assign cmd_autopre = cmd_autopre_ff;
	assign burst_busy = (burst_cnt_ff != 4'h0);
	assign bank_open = bank_open_ff;
	assign mr_otf = {fixed4_ff, otf_ff};
	assign pwr_state = pwr_ff;
	assign refresh_active = 1'b0;
	assign odt_uncertain = (win_cnt_ff != 4'h0) || (pwr_ff == DCD_S_PD);
	assign odt_enabled = (pwr_ff != DCD_S_SR) && pins.odt;
endmodule
`default_nettype wire

// >>> rtl/dcd_ctrl.sv
// memory controller end that drives the sdram command pins
`timescale 1ns/10ps
`default_nettype none
`include "dcd_map.svh"
module dcd_ctrl
	import dcd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	dcd_if.ctrl pins,
	input wire logic req_valid,
	input wire dcd_cmd_e req_cmd,
	input wire logic [`DCD_BA_W-1:0] req_bank,
	input wire logic [`DCD_ADDR_W-1:0] req_addr,
	input wire logic req_odt,
	input wire logic banks_idle,
	output logic req_ready,
	output logic req_refused,
	output logic srx_wait
);
	logic cke_ff;
	logic cs_n_ff;
	logic ras_n_ff;
	logic cas_n_ff;
	logic we_n_ff;
	logic [`DCD_BA_W-1:0] ba_ff;
	logic [`DCD_ADDR_W-1:0] addr_ff;
	logic refused_ff;
	logic [9:0] srx_cnt_ff;
	logic ok;

	// writes after self refresh exit held off self refresh only idle
	always_comb begin
		ok = 1'b1;
		if (req_cmd == DCD_C_WR && srx_cnt_ff != 10'h0) begin
			ok = 1'b0;
		end
		if (req_cmd == DCD_C_SRE && !banks_idle) begin
			ok = 1'b0;
		end
		if (req_cmd == DCD_C_ILL || req_cmd == DCD_C_NONE) begin
			ok = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cke_ff <= 1'b0;
			cs_n_ff <= 1'b1;
			ras_n_ff <= 1'b1;
			cas_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			ba_ff <= '0;
			addr_ff <= '0;
		end else begin
			// nop by default between operations
			cs_n_ff <= 1'b0;
			{ras_n_ff, cas_n_ff, we_n_ff} <= 3'h7;
			if (req_valid && ok) begin
				ba_ff <= req_bank;
				addr_ff <= req_addr;
				case (req_cmd)
					DCD_C_MRS: {ras_n_ff, cas_n_ff, we_n_ff} <= 3'h0;
					DCD_C_REF: {ras_n_ff, cas_n_ff, we_n_ff} <= 3'h1;
					DCD_C_SRE: begin
						{ras_n_ff, cas_n_ff, we_n_ff} <= 3'h1;
						cke_ff <= 1'b0;
					end
					DCD_C_PRE, DCD_C_PREA: {ras_n_ff, cas_n_ff, we_n_ff} <= 3'h2;
					DCD_C_ACT: {ras_n_ff, cas_n_ff, we_n_ff} <= 3'h3;
					DCD_C_WR: {ras_n_ff, cas_n_ff, we_n_ff} <= 3'h4;
					DCD_C_RD: {ras_n_ff, cas_n_ff, we_n_ff} <= 3'h5;
					DCD_C_ZQCL, DCD_C_ZQCS: {ras_n_ff, cas_n_ff, we_n_ff} <= 3'h6;
					DCD_C_PDE: cke_ff <= 1'b0;
					default: cke_ff <= 1'b1;
				endcase
				if (req_cmd == DCD_C_PRE) begin
					addr_ff[`DCD_A10] <= 1'b0;
				end
				if (req_cmd == DCD_C_PREA || req_cmd == DCD_C_ZQCL) begin
					addr_ff[`DCD_A10] <= 1'b1;
				end
				if (req_cmd == DCD_C_ZQCS) begin
					addr_ff[`DCD_A10] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			srx_cnt_ff <= 10'h0;
		end else if (req_valid && ok && req_cmd == DCD_C_SRX) begin
			srx_cnt_ff <= `DCD_SRX_WAIT;
		end else if (srx_cnt_ff != 10'h0) begin
			srx_cnt_ff <= srx_cnt_ff - 10'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			refused_ff <= 1'b0;
		end else begin
			refused_ff <= req_valid && !ok;
		end
	end

	assign pins.reset_n = reset_n;
	assign pins.cke = cke_ff;
	assign pins.cs_n = cs_n_ff;
	assign pins.ras_n = ras_n_ff;
	assign pins.cas_n = cas_n_ff;
	assign pins.we_n = we_n_ff;
	assign pins.ba = ba_ff;
	assign pins.addr = addr_ff;
	assign pins.odt = req_odt;
	assign req_ready = ok;
	assign req_refused = refused_ff;
	assign srx_wait = (srx_cnt_ff != 10'h0);
endmodule
`default_nettype wire

// >>> tb/dcd_chk.sv
// assertions on the command pins and the decoder outputs
`timescale 1ns/10ps
`default_nettype none
module dcd_chk
	import dcd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [13:0] addr,
	input wire dcd_cmd_e cmd,
	input wire logic [2:0] cmd_bank,
	input wire logic [3:0] cmd_burst,
	input wire logic cmd_autopre,
	input wire logic burst_busy,
	input wire logic [1:0] mr_otf,
	input wire dcd_pwr_e pwr_state,
	input wire logic odt_enabled
);
	logic cke_q_ff;
	logic sr_ff;
	logic [9:0] gap_ff;
	logic [3:0] pin;
	logic hh;
	assign pin = {cs_n, ras_n, cas_n, we_n};
	assign hh = cke && cke_q_ff;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// write hold-off after leaving self refresh
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cke_q_ff <= 1'b0;
			sr_ff <= 1'b0;
			gap_ff <= 10'h0;
		end else begin
			cke_q_ff <= cke;
			if (cke_q_ff && !cke && pin == 4'h1) begin
				sr_ff <= 1'b1;
			end else if (!cke_q_ff && cke) begin
				sr_ff <= 1'b0;
			end
			if (sr_ff && cke && !cke_q_ff) begin
				gap_ff <= 10'h1FF;
			end else if (gap_ff != 10'h0) begin
				gap_ff <= gap_ff - 10'h1;
			end
		end
	end
	pd_edge_nop_a: assert property ((cke != cke_q_ff) |->
		cs_n || pin == 4'h7 || (!cke && pin == 4'h1)) else $error("bad cke edge command");
	nop_keeps_a: assert property (hh && (cs_n || pin == 4'h7) |=>
		cmd == DCD_C_NONE) else $error("nop decoded as command");
	rd_decode_a: assert property (hh && pin == 4'h5 && !burst_busy |=> cmd == DCD_C_RD
		&& cmd_bank == $past(ba) && cmd_autopre == $past(addr[10])) else $error("read decode");
	wr_burst_a: assert property (hh && pin == 4'h4 && !burst_busy && mr_otf == 2'h1 |=>
		cmd == DCD_C_WR && cmd_burst == ($past(addr[12]) ? 4'h8 : 4'h4)) else $error("write burst");
	burst_runs_a: assert property (hh && pin[3:1] == 3'h2 && !burst_busy |=>
		burst_busy [*4]) else $error("burst cut short");
	sre_enter_a: assert property (cke_q_ff && !cke && pin == 4'h1 && pwr_state == DCD_S_IDLE
		|=> pwr_state == DCD_S_SR) else $error("self refresh not entered");
	sr_no_odt_a: assert property (pwr_state == DCD_S_SR |-> !odt_enabled)
		else $error("termination on in self refresh");
	srx_gap_a: assert property (gap_ff != 10'h0 |-> !(cke && pin == 4'h4))
		else $error("write too soon after exit");
	rd_c: cover property (hh && pin == 4'h5);
	sre_c: cover property (pwr_state == DCD_S_SR);
	pd_c: cover property (pwr_state == DCD_S_PD);
endmodule
`default_nettype wire

// >>> tb/ddr3_command_decoder_tb_top.sv
// self-checking bench for the command decoder and its controller
`timescale 1ns/10ps
`default_nettype none
module ddr3_command_decoder_tb_top
	import dcd_pkg::*;
;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	dcd_cmd_e req_cmd = DCD_C_NONE;
	logic [2:0] req_bank = 3'h0;
	logic [13:0] req_addr = 14'h0;
	logic req_odt = 1'b0;
	logic banks_idle = 1'b1;
	logic req_ready, req_refused, srx_wait, cmd_valid, cmd_autopre, burst_busy;
	logic odt_uncertain, odt_enabled, refresh_active;
	dcd_cmd_e cmd;
	dcd_pwr_e pwr_state;
	logic [2:0] cmd_bank;
	logic [13:0] cmd_addr;
	logic [3:0] cmd_burst;
	logic [7:0] bank_open;
	logic [1:0] mr_otf;
	int bad_count = 0;
	int cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	dcd_if pins ();
	dcd_ctrl dcd_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n), .pins(pins),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
		.req_odt(req_odt), .banks_idle(banks_idle), .req_ready(req_ready),
		.req_refused(req_refused), .srx_wait(srx_wait));
	dcd_device dcd_device_i (.clk_sys(clk_sys), .pins(pins), .wr_lat(4'h5), .cmd(cmd),
		.cmd_valid(cmd_valid), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_burst(cmd_burst),
		.cmd_autopre(cmd_autopre), .burst_busy(burst_busy), .bank_open(bank_open),
		.mr_otf(mr_otf), .pwr_state(pwr_state), .refresh_active(refresh_active),
		.odt_uncertain(odt_uncertain), .odt_enabled(odt_enabled));
	dcd_chk dcd_chk_i (.clk_sys(clk_sys), .reset_n(pins.reset_n), .cke(pins.cke),
		.cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
		.ba(pins.ba), .addr(pins.addr), .cmd(cmd), .cmd_bank(cmd_bank), .cmd_burst(cmd_burst),
		.cmd_autopre(cmd_autopre), .burst_busy(burst_busy), .mr_otf(mr_otf),
		.pwr_state(pwr_state), .odt_enabled(odt_enabled));
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_c(input string w, input dcd_cmd_e e, input dcd_cmd_e g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk_v(input string w, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic issue(input dcd_cmd_e c, input logic [2:0] b, input logic [13:0] a);
		int n;
		n = 0;
		req_cmd <= c;
		req_bank <= b;
		req_addr <= a;
		req_valid <= 1'b1;
		@(posedge clk_sys);
		while (req_ready !== 1'b1) begin
			n++;
			if (n > 20) begin
				bad_count++;
				end_of_test();
			end
			@(posedge clk_sys);
		end
		req_valid <= 1'b0;
	endtask
	task automatic run(input dcd_cmd_e c, input logic [2:0] b, input logic [13:0] a);
		int n;
		logic rw;
		n = 0;
		rw = (c == DCD_C_RD || c == DCD_C_WR);
		issue(c, b, a);
		// sampled at falling edges, where decoder outputs are settled
		while (cmd === DCD_C_NONE && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		chk_c("cmd", c, cmd);
		chk_v("valid", 16'h1, 16'(cmd_valid));
		chk_v("bank", 16'(b), 16'(cmd_bank));
		chk_v("addr", 16'(a), 16'(cmd_addr));
		chk_v("burst", rw ? (a[12] ? 16'h8 : 16'h4) : 16'h0, 16'(cmd_burst));
		chk_v("autopre", 16'(rw & a[10]), 16'(cmd_autopre));
		chk_v("idle_nop", 16'h7, 16'({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n}));
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic wait_pwr(input dcd_pwr_e p);
		int n;
		n = 0;
		while (pwr_state !== p && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		chk_v("pwr", 16'(p), 16'(pwr_state));
		@(posedge clk_sys);
	endtask
	task automatic refuse(input dcd_cmd_e c);
		req_cmd <= c;
		req_valid <= 1'b1;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		chk_v("refused", 16'h1, 16'(req_refused));
		@(posedge clk_sys);
	endtask
	task automatic t_decode();
		dcd_cmd_e c[10] = '{DCD_C_MRS, DCD_C_ACT, DCD_C_WR, DCD_C_RD, DCD_C_ACT, DCD_C_PRE,
			DCD_C_PREA, DCD_C_REF, DCD_C_ZQCL, DCD_C_ZQCS};
		logic [2:0] b[10] = '{3'h0, 3'h3, 3'h3, 3'h3, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
		logic [13:0] a[10] = '{14'h0001, 14'h0123, 14'h1010, 14'h0408, 14'h0042, 14'h0000,
			14'h0400, 14'h0000, 14'h0400, 14'h0000};
		logic [7:0] o[10] = '{8'h00, 8'h08, 8'h08, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00,
			8'h00};
		for (int i = 0; i < 10; i++) begin
			run(c[i], b[i], a[i]);
			chk_v("bank_open", 16'(o[i]), 16'(bank_open));
		end
		chk_v("otf", 16'h1, 16'(mr_otf));
	endtask
	task automatic t_busy();
		run(DCD_C_MRS, 3'h0, 14'h0002);
		chk_v("fixed4", 16'h2, 16'(mr_otf));
		// two reads back to back: the second lands inside the first burst
		req_cmd <= DCD_C_RD;
		req_bank <= 3'h4;
		req_addr <= 14'h1000;
		req_valid <= 1'b1;
		repeat (2) @(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		chk_c("rd_first", DCD_C_RD, cmd);
		chk_v("burst_fixed", 16'h4, 16'(cmd_burst));
		@(negedge clk_sys);
		chk_c("rd_second", DCD_C_ILL, cmd);
		chk_v("valid_ill", 16'h0, 16'(cmd_valid));
		chk_v("busy", 16'h1, 16'(burst_busy));
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic t_power();
		issue(DCD_C_PDE, 3'h0, 14'h0);
		wait_pwr(DCD_S_PD);
		chk_v("odt_unc", 16'h1, 16'(odt_uncertain));
		chk_v("refresh", 16'h0, 16'(refresh_active));
		issue(DCD_C_PDX, 3'h0, 14'h0);
		wait_pwr(DCD_S_IDLE);
		// window of write latency minus one cycles after the exit
		repeat (3) @(negedge clk_sys);
		chk_v("odt_win", 16'h1, 16'(odt_uncertain));
		@(negedge clk_sys);
		chk_v("odt_win_end", 16'h0, 16'(odt_uncertain));
		@(posedge clk_sys);
	endtask
	task automatic t_self();
		int n;
		n = 0;
		refuse(DCD_C_ILL);
		banks_idle <= 1'b0;
		refuse(DCD_C_SRE);
		banks_idle <= 1'b1;
		req_odt <= 1'b1;
		issue(DCD_C_SRE, 3'h0, 14'h0);
		chk_v("odt_on", 16'h1, 16'(odt_enabled));
		wait_pwr(DCD_S_SR);
		chk_v("odt_en", 16'h0, 16'(odt_enabled));
		req_odt <= 1'b0;
		issue(DCD_C_SRX, 3'h0, 14'h0);
		wait_pwr(DCD_S_IDLE);
		refuse(DCD_C_WR);
		while (srx_wait === 1'b1 && n < 600) begin
			@(negedge clk_sys);
			n++;
		end
		// three cycles of the hold already pass in wait_pwr and refuse
		chk_v("srx_hold", 16'h1FD, 16'(n));
		@(posedge clk_sys);
		run(DCD_C_WR, 3'h2, 14'h0008);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		issue(DCD_C_PDX, 3'h0, 14'h0);
		repeat (4) @(posedge clk_sys);
		t_decode();
		t_busy();
		t_power();
		t_self();
		end_of_test();
	end
endmodule
`default_nettype wire
